//--- verilog/rio_map.svh
// bit positions, codes and register offsets of the remote i/o exchange
`ifndef RIO_MAP_SVH
`define RIO_MAP_SVH
`define RIO_NARROW_MASK    16'h00ff
`define RIO_COMMAND_TRIGGER_BIT       14
`define RIO_STAT_BIT       15
`define RIO_CODE_MSB       12
`define RIO_CLS_MSB        12
`define RIO_CLS_LSB        11
`define RIO_HI_MSB         10
`define RIO_HI_LSB         6
`define RIO_IDX_MSB        5
`define RIO_CLS_PRD        2'h0
`define RIO_CLS_PWR        2'h1
`define RIO_CLS_MON        2'h2
`define RIO_CLS_MNT        2'h3
`define RIO_MON_OUT        6'h00
`define RIO_MON_IN         6'h01
`define RIO_MON_CNT        6'h02
`define RIO_MNT_OPS        6'h04
`define RIO_ASYNC_UPDATE   8'h20
`define RIO_IN_SEL_MSB     2
`define RIO_IN_SEL_LSB     0
`define RIO_IN_START       3
`define RIO_IN_HOME        4
`define RIO_IN_STOP        5
`define RIO_IN_FREE        6
`define RIO_IN_DSEL_MSB    10
`define RIO_IN_DSEL_LSB    8
`define RIO_IN_SEQUENTIAL_RUN_REQUEST      11
`define RIO_IN_JOGP        12
`define RIO_IN_JOGN        13
`define RIO_IN_FWD         14
`define RIO_IN_RVS         15
`define RIO_REG_CTRL       8'h00
`define RIO_REG_CODE       8'h04
`define RIO_REG_VALUE      8'h08
`define RIO_REG_INWORD     8'h0c
`define RIO_REG_OUTWORD    8'h10
`define RIO_REG_RSP        8'h14
`define RIO_REG_RSPVAL     8'h18
`define RIO_REG_IRQ_ST     8'h1c
`define RIO_REG_IRQ_CLR    8'h20
`define RIO_REG_IRQ_EN     8'h24
`define RIO_REG_UPDATE     8'h28
`define RIO_CTRL_WIDE      0
`define RIO_CTRL_ISSUE     1
`define RIO_RSP_BUSY       16
`define RIO_IRQ_DONE       0
`define RIO_IRQ_ABN        1
`define RIO_IRQ_REFUSED    2
`define RIO_IRQ_UPDATED    3
`endif

//--- verilog/rio_pkg.sv
// types and helpers shared by both ends of the remote i/o exchange
package rio_pkg;
  typedef logic [15:0] rio_word_t;
  typedef logic [31:0] rio_data_t;
  typedef logic [12:0] rio_code_t;
  typedef logic [3:0]  rio_irq_t;
  typedef enum logic [1:0] {rio_d_idle, rio_d_exec, rio_d_done} rio_dstate_e;
  typedef enum logic [1:0] {rio_c_idle, rio_c_wait, rio_c_clear} rio_cstate_e;
  // link field holds byte 0 in the top lane, so a value is byte-reversed
  function automatic rio_data_t rio_le_swap(input rio_data_t v);
    rio_le_swap = {v[7:0], v[15:8], v[23:16], v[31:24]};
  endfunction
endpackage

//--- verilog/rio_link_if.sv
// link between the network converter end and the driver end
`timescale 1ns/1ps
interface rio_link_if;
  import rio_pkg::*;
  logic      wide_mode;
  rio_word_t in_word;
  rio_word_t out_word;
  rio_word_t cmd_word;
  rio_data_t cmd_data;
  rio_word_t rsp_word;
  rio_data_t rsp_data;
  modport drv (input wide_mode, input in_word, input cmd_word,
               input cmd_data, output out_word, output rsp_word,
               output rsp_data);
  modport conv (output wide_mode, output in_word, output cmd_word,
                output cmd_data, input out_word, input rsp_word,
                input rsp_data);
endinterface

//--- verilog/rio_drv_end.sv
// driver end: remote i/o words and remote register command execution
//
// What this block does
// - wide mode: sixteen input bits, upper requests
// - narrow mode: eight input bits only
// - low input byte decodes select, start, stop
// - output word sixteen or eight status bits
// - command runs only on trigger rising edge
// - code selects read, write, monitor, maintenance
// - command data is little endian
// - completion trigger rises when command finished
// - status bit shows abnormal completion
// - response echoes the command code
// - response data is little endian
// - converter refreshes words via update command
`timescale 1ns/1ps
`include "rio_map.svh"
module rio_drv_end #(
  parameter int PARAM_DEPTH = 64
) (
  input  logic              clk_sys,
  input  logic              rst_b,
  rio_link_if.drv           link,
  output logic [2:0]        data_select_bit,
  output logic              pos_start,
  output logic              home_start,
  output logic              stop_request,
  output logic              free_request,
  output logic [2:0]        direct_select_run,
  output logic              sequential_run_request,
  output logic              inch_positive,
  output logic              inch_negative,
  output logic              run_positive,
  output logic              run_negative,
  input  logic [2:0]        select_bit_echo,
  input  logic              start_echo,
  input  logic              home_position,
  input  logic              ready_flag,
  input  logic              warning_flag,
  input  logic              alarm_flag,
  input  logic              sequence_busy_flag,
  input  logic [2:0]        zone_flag,
  input  logic              timing_flag,
  input  logic              moving_flag,
  input  logic              end_flag,
  input  logic              torque_limit_flag,
  output logic              param_wr_pulse,
  output logic [5:0]        param_wr_index,
  output rio_pkg::rio_data_t param_wr_value,
  output logic              maint_pulse,
  output logic [1:0]        maint_op
);
  import rio_pkg::*;

  rio_word_t   net_input_bit;
  rio_word_t   net_output_bit;
  rio_word_t   next_output;
  logic        command_trigger_q;
  logic        command_trigger_rise;
  rio_code_t   cmd_code;
  rio_data_t   cmd_value;
  rio_dstate_e state;
  logic        completion_trigger;
  logic        rsp_status;
  rio_code_t   rsp_code;
  rio_data_t   rsp_value;
  rio_data_t   done_count;
  rio_data_t   param_mem [PARAM_DEPTH];
  logic [1:0]  cls;
  logic [5:0]  idx;
  logic        idx_bad;
  logic        next_abn;
  rio_data_t   next_value;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      net_input_bit <= '0;
    end else if (link.wide_mode) begin
      net_input_bit <= link.in_word;
    end else begin
      net_input_bit <= link.in_word & `RIO_NARROW_MASK;
    end
  end

  assign data_select_bit = net_input_bit[`RIO_IN_SEL_MSB:`RIO_IN_SEL_LSB];
  assign pos_start       = net_input_bit[`RIO_IN_START];
  assign home_start      = net_input_bit[`RIO_IN_HOME];
  assign stop_request    = net_input_bit[`RIO_IN_STOP];
  assign free_request    = net_input_bit[`RIO_IN_FREE];
  assign direct_select_run =
    net_input_bit[`RIO_IN_DSEL_MSB:`RIO_IN_DSEL_LSB];
  assign sequential_run_request = net_input_bit[`RIO_IN_SEQUENTIAL_RUN_REQUEST];
  assign inch_positive   = net_input_bit[`RIO_IN_JOGP];
  assign inch_negative   = net_input_bit[`RIO_IN_JOGN];
  assign run_positive    = net_input_bit[`RIO_IN_FWD];
  assign run_negative    = net_input_bit[`RIO_IN_RVS];

  // status word, upper byte dropped in narrow mode
  always_comb begin
    next_output = {torque_limit_flag, end_flag, moving_flag, timing_flag,
                   zone_flag, sequence_busy_flag, alarm_flag, warning_flag,
                   ready_flag, home_position, start_echo, select_bit_echo};
    if (!link.wide_mode) begin
      next_output = next_output & `RIO_NARROW_MASK;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      net_output_bit <= '0;
    end else begin
      net_output_bit <= next_output;
    end
  end
  assign link.out_word = net_output_bit;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      command_trigger_q <= 1'b0;
    end else begin
      command_trigger_q <= link.cmd_word[`RIO_COMMAND_TRIGGER_BIT];
    end
  end
  assign command_trigger_rise = link.cmd_word[`RIO_COMMAND_TRIGGER_BIT] & ~command_trigger_q;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cmd_code  <= '0;
      cmd_value <= '0;
    end else if (state == rio_d_idle && command_trigger_rise) begin
      cmd_code  <= link.cmd_word[`RIO_CODE_MSB:0];
      cmd_value <= rio_le_swap(link.cmd_data);
    end
  end

  assign cls     = cmd_code[`RIO_CLS_MSB:`RIO_CLS_LSB];
  assign idx     = cmd_code[`RIO_IDX_MSB:0];
  // upper index bits must be zero; the array is never addressed beyond it
  assign idx_bad = (cmd_code[`RIO_HI_MSB:`RIO_HI_LSB] != '0)
                   || (int'(idx) >= PARAM_DEPTH);

  always_comb begin
    next_abn   = idx_bad;
    next_value = '0;
    case (cls)
      `RIO_CLS_PRD: begin
        if (!idx_bad) begin
          next_value = param_mem[idx];
        end
      end
      `RIO_CLS_PWR: begin
        next_value = '0;
      end
      `RIO_CLS_MON: begin
        case (idx)
          `RIO_MON_OUT: next_value = {16'h0000, net_output_bit};
          `RIO_MON_IN:  next_value = {16'h0000, net_input_bit};
          `RIO_MON_CNT: next_value = done_count;
          default:      next_abn   = 1'b1;
        endcase
      end
      `RIO_CLS_MNT: begin
        next_abn = idx_bad || (idx >= `RIO_MNT_OPS);
      end
      default: begin
        next_abn = 1'b1;
      end
    endcase
  end

  // parameter store holds data only, so it carries no reset
  always_ff @(posedge clk_sys) begin
    if (state == rio_d_exec && cls == `RIO_CLS_PWR && !idx_bad) begin
      param_mem[idx] <= cmd_value;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      param_wr_pulse <= 1'b0;
      param_wr_index <= '0;
      param_wr_value <= '0;
      maint_pulse    <= 1'b0;
      maint_op       <= '0;
    end else begin
      param_wr_pulse <= state == rio_d_exec && cls == `RIO_CLS_PWR
                        && !idx_bad;
      maint_pulse    <= state == rio_d_exec && cls == `RIO_CLS_MNT
                        && !next_abn;
      if (state == rio_d_exec) begin
        param_wr_index <= idx;
        param_wr_value <= cmd_value;
        maint_op       <= idx[1:0];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state <= rio_d_idle;
    end else begin
      case (state)
        rio_d_idle: if (command_trigger_rise) state <= rio_d_exec;
        rio_d_exec: state <= rio_d_done;
        rio_d_done: if (!link.cmd_word[`RIO_COMMAND_TRIGGER_BIT]) state <= rio_d_idle;
        default:    state <= rio_d_idle;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      completion_trigger <= 1'b0;
    end else if (state == rio_d_exec) begin
      completion_trigger <= 1'b1;
    end else if (state == rio_d_done && !link.cmd_word[`RIO_COMMAND_TRIGGER_BIT]) begin
      completion_trigger <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rsp_status <= 1'b0;
      rsp_code   <= '0;
      rsp_value  <= '0;
      done_count <= '0;
    end else if (state == rio_d_exec) begin
      rsp_status <= next_abn;
      rsp_code   <= cmd_code;
      rsp_value  <= next_value;
      done_count <= done_count + 32'h0000_0001;
    end
  end

  assign link.rsp_word = {rsp_status, completion_trigger, 1'b0, rsp_code};
  assign link.rsp_data = rio_le_swap(rsp_value);
endmodule

//--- verilog/rio_conv_end.sv
// converter end: register port, remote i/o refresh and command issue
`timescale 1ns/1ps
`include "rio_map.svh"
module rio_conv_end (
  input  logic        clk_sys,
  input  logic        rst_b,
  rio_link_if.conv    link,
  input  logic [7:0]  reg_addr,
  input  logic [31:0] reg_wdata,
  input  logic        reg_wr,
  input  logic        reg_rd,
  output logic [31:0] reg_rdata,
  output logic        irq
);
  import rio_pkg::*;

  rio_cstate_e state;
  logic        wide_mode;
  rio_code_t   code;
  rio_data_t   value;
  rio_word_t   in_hold;
  rio_word_t   in_sent;
  rio_word_t   out_seen;
  logic        command_trigger;
  logic        rsp_status;
  rio_code_t   rsp_code;
  rio_data_t   rsp_value;
  rio_irq_t    irq_status;
  rio_irq_t    irq_enable;
  rio_irq_t    irq_set;
  logic        issue;
  logic        accept;
  logic        update;
  logic        done;
  logic        cmp;

  assign cmp    = link.rsp_word[`RIO_COMMAND_TRIGGER_BIT];
  assign issue  = reg_wr && reg_addr == `RIO_REG_CTRL
                  && reg_wdata[`RIO_CTRL_ISSUE];
  assign accept = issue && state == rio_c_idle && !cmp;
  assign update = reg_wr && reg_addr == `RIO_REG_UPDATE
                  && reg_wdata[7:0] == `RIO_ASYNC_UPDATE;
  assign done   = state == rio_c_wait && cmp;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wide_mode <= 1'b0;
      code      <= '0;
      value     <= '0;
      in_hold   <= '0;
    end else if (reg_wr) begin
      case (reg_addr)
        `RIO_REG_CTRL:   wide_mode <= reg_wdata[`RIO_CTRL_WIDE];
        `RIO_REG_CODE:   code      <= reg_wdata[`RIO_CODE_MSB:0];
        `RIO_REG_VALUE:  value     <= reg_wdata;
        `RIO_REG_INWORD: in_hold   <= reg_wdata[15:0];
        default:         ;
      endcase
    end
  end

  // words move only on the update command
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      in_sent  <= '0;
      out_seen <= '0;
    end else if (update) begin
      in_sent  <= wide_mode ? in_hold : (in_hold & `RIO_NARROW_MASK);
      out_seen <= link.out_word;
    end
  end

  // trigger rises per command, falls after completion
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state           <= rio_c_idle;
      command_trigger <= 1'b0;
    end else begin
      case (state)
        rio_c_idle: if (accept) begin
          state           <= rio_c_wait;
          command_trigger <= 1'b1;
        end
        rio_c_wait: if (cmp) begin
          state           <= rio_c_clear;
          command_trigger <= 1'b0;
        end
        rio_c_clear: if (!cmp) state <= rio_c_idle;
        default: begin
          state           <= rio_c_idle;
          command_trigger <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rsp_status <= 1'b0;
      rsp_code   <= '0;
      rsp_value  <= '0;
    end else if (done) begin
      rsp_status <= link.rsp_word[`RIO_STAT_BIT];
      rsp_code   <= link.rsp_word[`RIO_CODE_MSB:0];
      rsp_value  <= rio_le_swap(link.rsp_data);
    end
  end

  assign link.wide_mode = wide_mode;
  assign link.in_word   = in_sent;
  assign link.cmd_word  = {1'b0, command_trigger, 1'b0, code};
  assign link.cmd_data  = rio_le_swap(value);

  always_comb begin
    irq_set = '0;
    irq_set[`RIO_IRQ_DONE]    = done;
    irq_set[`RIO_IRQ_ABN]     = done && link.rsp_word[`RIO_STAT_BIT];
    irq_set[`RIO_IRQ_REFUSED] = issue && !accept;
    irq_set[`RIO_IRQ_UPDATED] = update;
  end

  // a new event wins over a clear in the same cycle
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      irq_status <= '0;
      irq_enable <= '0;
    end else begin
      if (reg_wr && reg_addr == `RIO_REG_IRQ_CLR) begin
        irq_status <= (irq_status & ~reg_wdata[3:0]) | irq_set;
      end else begin
        irq_status <= irq_status | irq_set;
      end
      if (reg_wr && reg_addr == `RIO_REG_IRQ_EN) begin
        irq_enable <= reg_wdata[3:0];
      end
    end
  end
  assign irq = |(irq_status & irq_enable);

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        `RIO_REG_CTRL:    reg_rdata <= {31'h0, wide_mode};
        `RIO_REG_CODE:    reg_rdata <= {19'h0, code};
        `RIO_REG_VALUE:   reg_rdata <= value;
        `RIO_REG_INWORD:  reg_rdata <= {16'h0, in_hold};
        `RIO_REG_OUTWORD: reg_rdata <= {16'h0, out_seen};
        `RIO_REG_RSP:     reg_rdata <= {15'h0, state != rio_c_idle,
                                        rsp_status, 2'h0, rsp_code};
        `RIO_REG_RSPVAL:  reg_rdata <= rsp_value;
        `RIO_REG_IRQ_ST:  reg_rdata <= {28'h0, irq_status};
        `RIO_REG_IRQ_EN:  reg_rdata <= {28'h0, irq_enable};
        default:          reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end
endmodule

//--- test/rio_link_monitor.sv
// concurrent checks on the link between converter and driver ends
`timescale 1ns/1ps
`include "rio_map.svh"
module rio_link_monitor (
  input logic               clk_sys,
  input logic               rst_b,
  input logic               wide_mode,
  input rio_pkg::rio_word_t in_word,
  input rio_pkg::rio_word_t out_word,
  input rio_pkg::rio_word_t cmd_word,
  input rio_pkg::rio_data_t cmd_data,
  input rio_pkg::rio_word_t rsp_word,
  input rio_pkg::rio_data_t rsp_data
);
  import rio_pkg::*;
  logic trg;
  logic cmp;
  assign trg = cmd_word[`RIO_COMMAND_TRIGGER_BIT];
  assign cmp = rsp_word[`RIO_COMMAND_TRIGGER_BIT];
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  property p_cmp_after_command_trigger;
    $rose(trg) && !cmp |-> ##[1:3] cmp;
  endproperty
  a_cmp_after_command_trigger: assert property (p_cmp_after_command_trigger)
    else $error("completion did not follow trigger");
  property p_cmp_cause;
    $rose(cmp) |-> trg && $past(trg);
  endproperty
  a_cmp_cause: assert property (p_cmp_cause)
    else $error("completion rose without a held trigger");
  property p_code_echo;
    $rose(cmp) |-> rsp_word[`RIO_CODE_MSB:0] == cmd_word[`RIO_CODE_MSB:0];
  endproperty
  a_code_echo: assert property (p_code_echo)
    else $error("response code differs from command code");
  property p_rsp_stable;
    cmp && trg |=> $stable(rsp_word);
  endproperty
  a_rsp_stable: assert property (p_rsp_stable)
    else $error("response word moved while trigger held");
  property p_cmp_drop;
    cmp && !trg |-> ##[1:2] !cmp;
  endproperty
  a_cmp_drop: assert property (p_cmp_drop)
    else $error("completion stayed high after trigger low");
  property p_command_trigger_release;
    cmp && trg |-> ##[1:3] !trg;
  endproperty
  a_command_trigger_release: assert property (p_command_trigger_release)
    else $error("trigger not released after completion");
  property p_no_retrigger;
    $rose(trg) |-> !cmp;
  endproperty
  a_no_retrigger: assert property (p_no_retrigger)
    else $error("trigger raised while completion high");
  property p_narrow_out;
    !wide_mode && $past(!wide_mode, 2) |-> out_word[15:8] == 8'h00;
  endproperty
  a_narrow_out: assert property (p_narrow_out)
    else $error("narrow mode output word has upper bits");

  c_normal: cover property ($rose(cmp) && !rsp_word[`RIO_STAT_BIT]);
  c_abnormal: cover property ($rose(cmp) && rsp_word[`RIO_STAT_BIT]);
  c_wide_in: cover property (wide_mode && $changed(in_word));
endmodule

//--- test/rio_tb_top.sv
// testbench joining the converter end and the driver end
`timescale 1ns/1ps
`include "rio_map.svh"
module rio_tb_top;
  import rio_pkg::*;
  logic        clk_sys;
  logic        rst_b;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic        irq;
  logic [15:0] status_in;
  wire  [15:0] req_out;
  logic        param_wr_pulse;
  logic [5:0]  param_wr_index;
  rio_data_t   param_wr_value;
  logic        maint_pulse;
  logic [1:0]  maint_op;
  logic [5:0]  seen_index;
  rio_data_t   seen_value;
  logic [1:0]  seen_op;
  int          mismatches;
  int          n_compared;
  int          cycles;
  int          n_wr_pulse;
  int          n_maint;

  // bit 7 of the request word has no driver output behind it
  assign req_out[7] = 1'b0;
  rio_link_if i_rio_link_if ();
  rio_drv_end #(.PARAM_DEPTH(64)) i_rio_drv_end (
    .clk_sys (clk_sys), .rst_b (rst_b), .link (i_rio_link_if.drv),
    .data_select_bit (req_out[2:0]), .pos_start (req_out[3]),
    .home_start (req_out[4]), .stop_request (req_out[5]),
    .free_request (req_out[6]), .direct_select_run (req_out[10:8]),
    .sequential_run_request (req_out[11]), .inch_positive (req_out[12]),
    .inch_negative (req_out[13]), .run_positive (req_out[14]),
    .run_negative (req_out[15]), .select_bit_echo (status_in[2:0]),
    .start_echo (status_in[3]), .home_position (status_in[4]),
    .ready_flag (status_in[5]), .warning_flag (status_in[6]),
    .alarm_flag (status_in[7]), .sequence_busy_flag (status_in[8]),
    .zone_flag (status_in[11:9]), .timing_flag (status_in[12]),
    .moving_flag (status_in[13]), .end_flag (status_in[14]),
    .torque_limit_flag (status_in[15]),
    .param_wr_pulse (param_wr_pulse), .param_wr_index (param_wr_index),
    .param_wr_value (param_wr_value), .maint_pulse (maint_pulse),
    .maint_op (maint_op));
  rio_conv_end i_rio_conv_end (
    .clk_sys (clk_sys), .rst_b (rst_b), .link (i_rio_link_if.conv),
    .reg_addr (reg_addr), .reg_wdata (reg_wdata), .reg_wr (reg_wr),
    .reg_rd (reg_rd), .reg_rdata (reg_rdata), .irq (irq));
  rio_link_monitor i_rio_link_monitor (
    .clk_sys (clk_sys), .rst_b (rst_b),
    .wide_mode (i_rio_link_if.wide_mode),
    .in_word (i_rio_link_if.in_word), .out_word (i_rio_link_if.out_word),
    .cmd_word (i_rio_link_if.cmd_word), .cmd_data (i_rio_link_if.cmd_data),
    .rsp_word (i_rio_link_if.rsp_word), .rsp_data (i_rio_link_if.rsp_data));

  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask

  task automatic irq_is(input logic v);
    #1 chk({31'h0, irq}, {31'h0, v});
  endtask

  // waits a bounded time for the done interrupt, then lets the link settle
  task automatic wait_done();
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 50) begin
      @(posedge clk_sys);
      n++;
    end
    irq_is(1'b1);
    repeat (6) @(posedge clk_sys);
  endtask

  task automatic cmd(input logic [12:0] code, input rio_data_t v,
                     input logic abn);
    wr(`RIO_REG_CODE, {19'h0, code});
    wr(`RIO_REG_VALUE, v);
    wr(`RIO_REG_CTRL, 32'h3);
    wait_done();
    rdc(`RIO_REG_RSP, {16'h0, abn, 2'h0, code});
    wr(`RIO_REG_IRQ_CLR, 32'hf);
  endtask

  always @(posedge clk_sys) begin
    cycles++;
    if (param_wr_pulse === 1'b1) begin
      n_wr_pulse++;
      seen_index = param_wr_index;
      seen_value = param_wr_value;
    end
    if (maint_pulse === 1'b1) begin
      n_maint++;
      seen_op = maint_op;
    end
    if (cycles == 3000) begin
      mismatches++;
      results();
    end
  end

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  initial begin
    rst_b = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    status_in = 16'h0000;
    mismatches = 0;
    n_compared = 0;
    cycles = 0;
    n_wr_pulse = 0;
    n_maint = 0;
    repeat (3) @(posedge clk_sys);
    rst_b <= 1'b1;
    rdc(`RIO_REG_CTRL, 32'h0);
    rdc(`RIO_REG_RSP, 32'h0);
    rdc(`RIO_REG_IRQ_ST, 32'h0);
    rdc(8'h40, 32'h0);
    rdc(`RIO_REG_IRQ_CLR, 32'h0);
    wr(`RIO_REG_CTRL, 32'h1);
    status_in <= 16'h3c96;
    wr(`RIO_REG_INWORD, 32'ha5ff);
    wr(`RIO_REG_UPDATE, 32'h20);
    repeat (4) @(posedge clk_sys);
    chk({16'h0, req_out}, 32'ha57f);
    rdc(`RIO_REG_OUTWORD, 32'h3c96);
    rdc(`RIO_REG_IRQ_ST, 32'h8);
    irq_is(1'b0);
    wr(`RIO_REG_IRQ_EN, 32'h8);
    irq_is(1'b1);
    wr(`RIO_REG_IRQ_CLR, 32'h8);
    irq_is(1'b0);
    // only the update code refreshes the link words
    wr(`RIO_REG_INWORD, 32'hffff);
    wr(`RIO_REG_UPDATE, 32'h21);
    repeat (4) @(posedge clk_sys);
    chk({16'h0, req_out}, 32'ha57f);
    wr(`RIO_REG_CTRL, 32'h0);
    status_in <= 16'hffff;
    wr(`RIO_REG_UPDATE, 32'h20);
    repeat (4) @(posedge clk_sys);
    chk({16'h0, req_out}, 32'h7f);
    rdc(`RIO_REG_OUTWORD, 32'hff);
    wr(`RIO_REG_IRQ_CLR, 32'hf);
    wr(`RIO_REG_IRQ_EN, 32'h3);
    cmd(13'h0805, 32'h12345678, 1'b0);
    chk({26'h0, seen_index}, 32'h5);
    chk(seen_value, 32'h12345678);
    // byte 0 of the value travels in the top lane of the link
    chk(i_rio_link_if.cmd_data, 32'h78563412);
    cmd(13'h0005, 32'h0, 1'b0);
    rdc(`RIO_REG_RSPVAL, 32'h12345678);
    chk(i_rio_link_if.rsp_data, 32'h78563412);
    cmd(13'h1000, 32'h0, 1'b0);
    rdc(`RIO_REG_RSPVAL, 32'hffff);
    cmd(13'h1001, 32'h0, 1'b0);
    rdc(`RIO_REG_RSPVAL, 32'hff);
    // four commands have completed before this one executes
    cmd(13'h1002, 32'h0, 1'b0);
    rdc(`RIO_REG_RSPVAL, 32'h4);
    cmd(13'h1802, 32'h0, 1'b0);
    chk({30'h0, seen_op}, 32'h2);
    cmd(13'h0045, 32'h0, 1'b1);
    rdc(`RIO_REG_RSPVAL, 32'h0);
    // a second issue while the first is pending must be refused
    wr(`RIO_REG_IRQ_EN, 32'h1);
    wr(`RIO_REG_CODE, 32'h1000);
    wr(`RIO_REG_CTRL, 32'h3);
    wr(`RIO_REG_CTRL, 32'h3);
    wait_done();
    rdc(`RIO_REG_IRQ_ST, 32'h5);
    chk(n_wr_pulse, 32'h1);
    chk(n_maint, 32'h1);
    // reset after the last command has finished returns both ends to idle
    rst_b <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rst_b <= 1'b1;
    rdc(`RIO_REG_RSP, 32'h0);
    rdc(`RIO_REG_IRQ_ST, 32'h0);
    chk({16'h0, req_out}, 32'h0);
    results();
  end
endmodule
